// *** pkg/edit_consts.vh ***
// Purpose: Constants for the numeric edit engine and field registers
// Assumes: Byte offsets on a 32-bit AHB-Lite register bus
// Notes:   Memory words are 16 bits; one character per word
`ifndef EDIT_CONSTS_VH
`define EDIT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_CTRL  8'h00
`define A_PROG  8'h04
`define A_SRC   8'h08
`define A_DST   8'h0C
`define A_STAT  8'h10
`define A_LONG  8'h14
`define A_FCMD  8'h18
`define A_EA    8'h1C
`define A_FP0   8'h20
`define A_FP1   8'h24
`define A_FL0   8'h28
`define A_FL1   8'h2C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_START 0
`define CTRL_ZERO  1
`define ENT_LAST   15
`define ENT_OP_HI  14
`define ENT_OP_LO  11
`define ENT_M_HI   7
`define ENT_M_LO   0
`define FC_OP_HI   2
`define FC_SEL     3
`define FC_IMM_HI  31
`define FC_IMM_LO  16
`define FP_BIT_HI  3
`define FP_OFS_HI  25
`define FP_SEG_LO  26
`define FL_W       27
`define FL_KEEP    21

// ----------------------------------------
// Edit opcodes
// ----------------------------------------
`define OP_SUPPRESS 4'h0
`define OP_LITERAL  4'h1
`define OP_SET_ZS   4'h2
`define OP_IF_SIG   4'h3
`define OP_DIGITS   4'h4
`define OP_IF_NEG   4'h5
`define OP_IF_POS   4'h6
`define OP_SET_FLT  4'h7
`define OP_FLT_POS  4'h8
`define OP_FLT_NEG  4'h9
`define OP_FLT_SIGN 4'hA
`define OP_SKIP     4'hB
`define OP_FILL     4'hC
`define OP_FORCE    4'hD
`define OP_SIGN     4'hE

// ----------------------------------------
// Field commands and characters
// ----------------------------------------
`define FC_LONG_TO_LEN 3'h1
`define FC_ADDR_TO_PTR 3'h2
`define FC_LEN_IMM     3'h3
`define FC_ADD_OFS     3'h4
`define FC_LEN_TO_LONG 3'h5
`define FC_STORE_PTR   3'h6
`define CH_BLANK 8'hA0
`define CH_MINUS 8'hAD
`define CH_ZERO  8'hB0
`define RST_WORD 32'h0000_0000

`endif

// *** src/field_regs.v ***
// Purpose: Field pointer and field length registers
// Assumes: One command strobe per cycle at most
// Notes:   Pointer store to memory is sequenced by the parent
`timescale 1ns/100ps
`include "edit_consts.vh"

module field_regs (
  // Clock and reset
  input  wire                hclk,
  input  wire                hresetn,
  // Command
  input  wire                cmd_stb,
  input  wire [2:0]          cmd_op,
  input  wire                cmd_sel,
  input  wire [15:0]         cmd_imm,
  input  wire [31:0]         long_in,
  input  wire [31:0]         ea_in,
  // Register contents
  output wire [31:0]         fp0,
  output wire [31:0]         fp1,
  output wire [`FL_W-1:0]    fl0,
  output wire [`FL_W-1:0]    fl1,
  output wire [31:0]         long_res,
  output wire                long_we
);

  reg [31:0]       fp_r [0:1];
  reg [`FL_W-1:0]  fl_r [0:1];
  wire [25:0]      ofs_sum;

  assign fp0 = fp_r[0];
  assign fp1 = fp_r[1];
  assign fl0 = fl_r[0];
  assign fl1 = fl_r[1];
  // Sum wraps; caller keeps it within the low 20 bits
  assign ofs_sum = fp_r[cmd_sel][`FP_OFS_HI:0] + long_in[25:0];
  assign long_res = {11'h000, fl_r[cmd_sel][`FL_KEEP-1:0]};
  assign long_we = cmd_stb && (cmd_op == `FC_LEN_TO_LONG);

  // ----------------------------------------
  // Register updates
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_r[0] <= `RST_WORD;
      fp_r[1] <= `RST_WORD;
      fl_r[0] <= {`FL_W{1'b0}};
      fl_r[1] <= {`FL_W{1'b0}};
    end else if (cmd_stb) begin
      case (cmd_op)
        `FC_LONG_TO_LEN: fl_r[cmd_sel] <= long_in[`FL_W-1:0];
        `FC_ADDR_TO_PTR: fp_r[cmd_sel] <= ea_in;
        `FC_LEN_IMM: fl_r[cmd_sel] <= {11'h000, cmd_imm};
        `FC_ADD_OFS: fp_r[cmd_sel] <=
          {fp_r[cmd_sel][31:`FP_SEG_LO], ofs_sum};
        default: fp_r[cmd_sel] <= fp_r[cmd_sel];
      endcase
    end
  end

endmodule // field_regs

// *** src/numeric_edit_and_field_regs.v ***
// Purpose: Numeric edit engine and field register instructions
// Assumes: AHB-Lite slave; 16-bit memory port with req/ack
// Notes:   One character per memory word, low byte
`timescale 1ns/100ps
`include "edit_consts.vh"

module numeric_edit_and_field_regs (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Memory port
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SIGN  = 4'h1;
  localparam [3:0] S_FETCH = 4'h2;
  localparam [3:0] S_EXEC  = 4'h3;
  localparam [3:0] S_DIG   = 4'h4;
  localparam [3:0] S_FLT   = 4'h5;
  localparam [3:0] S_WR    = 4'h6;
  localparam [3:0] S_NEXT  = 4'h7;
  localparam [3:0] S_STORE = 4'h8;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [3:0]   state_r;
  reg [7:0]   addr_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg [31:0]  prog_r;
  reg [31:0]  src_r;
  reg [31:0]  dst_r;
  reg [31:0]  long_r;
  reg [31:0]  ea_r;
  reg [31:0]  pc_r;
  reg [31:0]  sp_r;
  reg [31:0]  dp_r;
  reg [15:0]  ent_r;
  reg [7:0]   cnt_r;
  reg [7:0]   zs_r;
  reg [7:0]   flt_r;
  reg [7:0]   sign_ch_r;
  reg [7:0]   wch_r;
  reg         fdef_r;
  reg         sig_r;
  reg         zero_r;
  reg         pend_r;
  reg         done_r;
  reg         fcmd_stb_r;
  reg [2:0]   fcmd_op_r;
  reg         fcmd_sel_r;
  reg [15:0]  fcmd_imm_r;
  reg [31:0]  st_ptr_r;
  reg [1:0]   st_idx_r;
  reg [1:0]   st_last_r;

  wire [31:0]        fp0;
  wire [31:0]        fp1;
  wire [`FL_W-1:0]   fl0;
  wire [`FL_W-1:0]   fl1;
  wire [31:0]        long_res;
  wire               long_we;
  wire [3:0]         op;
  wire [7:0]         m;
  wire               neg;
  wire [7:0]         dig;
  wire               busy;

  assign op   = ent_r[`ENT_OP_HI:`ENT_OP_LO];
  assign m    = ent_r[`ENT_M_HI:`ENT_M_LO];
  assign neg  = (sign_ch_r == `CH_MINUS);
  assign dig  = mem_rdata[7:0];
  assign busy = (state_r != S_IDLE);

  field_regs u_field (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .cmd_stb  (fcmd_stb_r),
    .cmd_op   (fcmd_op_r),
    .cmd_sel  (fcmd_sel_r),
    .cmd_imm  (fcmd_imm_r),
    .long_in  (long_r),
    .ea_in    (ea_r),
    .fp0      (fp0),
    .fp1      (fp1),
    .fl0      (fl0),
    .fl1      (fl1),
    .long_res (long_res),
    .long_we  (long_we)
  );

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `A_CTRL: rd_mux = {30'h0, zero_r, 1'b0};
        `A_PROG: rd_mux = prog_r;
        `A_SRC:  rd_mux = src_r;
        `A_DST:  rd_mux = dst_r;
        `A_STAT: rd_mux = {8'h00, flt_r, zs_r, 3'h0,
                           fdef_r, neg, sig_r, done_r, busy};
        `A_LONG: rd_mux = long_r;
        `A_EA:   rd_mux = ea_r;
        `A_FP0:  rd_mux = fp0;
        `A_FP1:  rd_mux = fp1;
        `A_FL0:  rd_mux = {5'h00, fl0};
        `A_FL1:  rd_mux = {5'h00, fl1};
        default: rd_mux = `RST_WORD;
      endcase
    end
  endfunction

  // Pointer words: segment/extend, word number, bit number
  function [15:0] ptr_word;
    input [31:0] p;
    input [1:0]  i;
    begin
      case (i)
        2'd0:    ptr_word = {3'h0, (p[`FP_BIT_HI:0] != 4'h0),
                             6'h00, p[31:`FP_SEG_LO]};
        2'd1:    ptr_word = p[19:4];
        default: ptr_word = {p[`FP_BIT_HI:0], 12'h000};
      endcase
    end
  endfunction

  // ----------------------------------------
  // Memory access launch
  // ----------------------------------------
  task go_rd;
    input [31:0] a;
    begin
      mem_req  <= 1'b1;
      mem_we   <= 1'b0;
      mem_addr <= a;
    end
  endtask

  task go_wr;
    input [31:0] a;
    input [7:0]  c;
    begin
      mem_req   <= 1'b1;
      mem_we    <= 1'b1;
      mem_addr  <= a;
      mem_wdata <= {8'h00, c};
    end
  endtask

  // ----------------------------------------
  // Bus slave and edit sequencer
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= `RST_WORD;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= `RST_WORD;
      mem_wdata  <= 16'h0000;
      state_r    <= S_IDLE;
      addr_r     <= 8'h00;
      wr_pend_r  <= 1'b0;
      rd_pend_r  <= 1'b0;
      prog_r     <= `RST_WORD;
      src_r      <= `RST_WORD;
      dst_r      <= `RST_WORD;
      long_r     <= `RST_WORD;
      ea_r       <= `RST_WORD;
      pc_r       <= `RST_WORD;
      sp_r       <= `RST_WORD;
      dp_r       <= `RST_WORD;
      ent_r      <= 16'h0000;
      cnt_r      <= 8'h00;
      zs_r       <= `CH_BLANK;
      flt_r      <= 8'h00;
      sign_ch_r  <= 8'h00;
      wch_r      <= 8'h00;
      fdef_r     <= 1'b0;
      sig_r      <= 1'b0;
      zero_r     <= 1'b0;
      pend_r     <= 1'b0;
      done_r     <= 1'b0;
      fcmd_stb_r <= 1'b0;
      fcmd_op_r  <= 3'h0;
      fcmd_sel_r <= 1'b0;
      fcmd_imm_r <= 16'h0000;
      st_ptr_r   <= `RST_WORD;
      st_idx_r   <= 2'd0;
      st_last_r  <= 2'd0;
    end else begin
      fcmd_stb_r <= 1'b0;
      if (long_we)
        long_r <= long_res;
      // Reads take one wait state so a write just before is seen
      if (rd_pend_r) begin
        hrdata    <= rd_mux(addr_r);
        hreadyout <= 1'b1;
      end
      if (hsel && hready && htrans[1]) begin
        addr_r    <= haddr[7:0];
        wr_pend_r <= hwrite;
        rd_pend_r <= !hwrite;
        if (!hwrite)
          hreadyout <= 1'b0;
      end else begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
      end
      if (wr_pend_r) begin
        case (addr_r)
          `A_PROG: prog_r <= hwdata;
          `A_SRC:  src_r  <= hwdata;
          `A_DST:  dst_r  <= hwdata;
          `A_LONG: long_r <= hwdata;
          `A_EA:   ea_r   <= hwdata;
          default: ;
        endcase
      end
      // Commands arriving while busy are dropped
      if (wr_pend_r && !busy && addr_r == `A_CTRL) begin
        zero_r <= hwdata[`CTRL_ZERO];
        if (hwdata[`CTRL_START]) begin
          zs_r    <= `CH_BLANK;
          fdef_r  <= 1'b0;
          sig_r   <= 1'b0;
          done_r  <= 1'b0;
          pc_r    <= prog_r;
          sp_r    <= src_r;
          dp_r    <= dst_r;
          go_rd(src_r);
          state_r <= S_SIGN;
        end
      end
      if (wr_pend_r && !busy && addr_r == `A_FCMD) begin
        fcmd_op_r  <= hwdata[`FC_OP_HI:0];
        fcmd_sel_r <= hwdata[`FC_SEL];
        fcmd_imm_r <= hwdata[`FC_IMM_HI:`FC_IMM_LO];
        if (hwdata[`FC_OP_HI:0] == `FC_STORE_PTR) begin
          st_ptr_r  <= hwdata[`FC_SEL] ? fp1 : fp0;
          st_last_r <= ((hwdata[`FC_SEL] ? fp1[`FP_BIT_HI:0]
                       : fp0[`FP_BIT_HI:0]) != 4'h0)
                       ? 2'd2 : 2'd1;
          st_idx_r  <= 2'd0;
          go_wr(ea_r, 8'h00);
          mem_wdata <= ptr_word(hwdata[`FC_SEL] ? fp1 : fp0, 2'd0);
          state_r   <= S_STORE;
        end else begin
          fcmd_stb_r <= 1'b1;
        end
      end
      case (state_r)
        S_IDLE: ;
        S_SIGN: if (mem_ack) begin
          sign_ch_r <= dig;
          sp_r      <= sp_r + 32'd1;
          go_rd(pc_r);
          state_r   <= S_FETCH;
        end
        S_FETCH: if (mem_ack) begin
          mem_req <= 1'b0;
          ent_r   <= mem_rdata;
          cnt_r   <= mem_rdata[`ENT_M_HI:`ENT_M_LO];
          state_r <= S_EXEC;
        end
        S_EXEC: begin
          state_r <= S_NEXT;
          case (op)
            `OP_SUPPRESS: if (cnt_r != 8'h00) begin
              go_rd(sp_r);
              state_r <= S_DIG;
            end
            `OP_DIGITS: begin
              sig_r  <= 1'b1;
              pend_r <= !sig_r && fdef_r;
              if (cnt_r != 8'h00) begin
                go_rd(sp_r);
                state_r <= S_DIG;
              end
            end
            `OP_LITERAL: begin
              go_wr(dp_r, m);
              state_r <= S_WR;
            end
            `OP_SET_ZS: zs_r <= m;
            `OP_IF_SIG: begin
              go_wr(dp_r, sig_r ? m : zs_r);
              state_r <= S_WR;
            end
            `OP_IF_NEG: begin
              go_wr(dp_r, neg ? m : zs_r);
              state_r <= S_WR;
            end
            `OP_IF_POS: begin
              go_wr(dp_r, neg ? zs_r : m);
              state_r <= S_WR;
            end
            `OP_SET_FLT: begin
              flt_r  <= m;
              fdef_r <= 1'b1;
            end
            `OP_FLT_POS: begin
              flt_r  <= neg ? zs_r : m;
              fdef_r <= 1'b1;
            end
            `OP_FLT_NEG: begin
              flt_r  <= neg ? m : zs_r;
              fdef_r <= 1'b1;
            end
            `OP_FLT_SIGN: begin
              flt_r  <= sign_ch_r;
              fdef_r <= 1'b1;
            end
            `OP_SKIP: if (zero_r)
              pc_r <= pc_r + {24'h000000, m};
            `OP_FILL: if (cnt_r != 8'h00) begin
              go_wr(dp_r, zs_r);
              state_r <= S_WR;
            end
            `OP_FORCE: sig_r <= 1'b1;
            `OP_SIGN: begin
              go_wr(dp_r, sign_ch_r);
              state_r <= S_WR;
            end
            default: ;
          endcase
        end
        S_DIG: if (mem_ack) begin
          sp_r    <= sp_r + 32'd1;
          wch_r   <= dig;
          state_r <= S_WR;
          if (op == `OP_DIGITS) begin
            if (pend_r) begin
              pend_r  <= 1'b0;
              go_wr(dp_r, flt_r);
              state_r <= S_FLT;
            end else
              go_wr(dp_r, dig);
          end else if (sig_r)
            go_wr(dp_r, dig);
          else if (dig != `CH_ZERO) begin
            sig_r <= 1'b1;
            if (fdef_r) begin
              go_wr(dp_r, flt_r);
              state_r <= S_FLT;
            end else
              go_wr(dp_r, dig);
          end else
            go_wr(dp_r, zs_r);
        end
        S_FLT: if (mem_ack) begin
          dp_r    <= dp_r + 32'd1;
          go_wr(dp_r + 32'd1, wch_r);
          state_r <= S_WR;
        end
        S_WR: if (mem_ack) begin
          dp_r    <= dp_r + 32'd1;
          cnt_r   <= cnt_r - 8'h01;
          mem_req <= 1'b0;
          state_r <= S_NEXT;
          if (cnt_r > 8'h01) begin
            if (op == `OP_FILL) begin
              go_wr(dp_r + 32'd1, zs_r);
              state_r <= S_WR;
            end else if (op == `OP_SUPPRESS ||
                         op == `OP_DIGITS) begin
              go_rd(sp_r);
              state_r <= S_DIG;
            end
          end
        end
        S_NEXT: begin
          pc_r <= pc_r + 32'd1;
          if (ent_r[`ENT_LAST]) begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            go_rd(pc_r + 32'd1);
            state_r <= S_FETCH;
          end
        end
        S_STORE: if (mem_ack) begin
          st_idx_r <= st_idx_r + 2'd1;
          if (st_idx_r == st_last_r) begin
            mem_req <= 1'b0;
            state_r <= S_IDLE;
          end else begin
            mem_addr  <= ea_r + {30'h0, st_idx_r + 2'd1};
            mem_wdata <= ptr_word(st_ptr_r, st_idx_r + 2'd1);
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // numeric_edit_and_field_regs

// *** testbench/edit_asserts.sv ***
// Purpose: Port assertions for numeric_edit_and_field_regs
// Assumes: One clock, hresetn async active low
// Notes:   Helper logic follows the AHB address phase
`timescale 1ns/100ps
module edit_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Memory port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack
);
  logic        ap_v_r;
  logic        ap_w_r;
  logic [7:0]  ap_a_r;
  logic [31:0] src_r;
  logic [31:0] prog_r;
  logic [31:0] ea_r;
  wire dp_w   = ap_v_r && ap_w_r && hreadyout;
  wire ctl_go = dp_w && ap_a_r == 8'h00 && hwdata[0];
  wire fc_w   = dp_w && ap_a_r == 8'h18;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v_r <= 1'b0;
    end else begin
      if (hready) begin
        ap_v_r <= hsel && htrans[1];
        ap_w_r <= hwrite;
        ap_a_r <= haddr[7:0];
      end
      if (dp_w && ap_a_r == 8'h04) prog_r <= hwdata;
      if (dp_w && ap_a_r == 8'h08) src_r <= hwdata;
      if (dp_w && ap_a_r == 8'h1C) ea_r <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_rd_wait_one: assert property (
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  chk_wr_no_wait: assert property (
    hsel && htrans[1] && hwrite && hready |=> hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_req_holds: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  chk_sign_first: assert property (
    ctl_go |-> ##[1:6] mem_req && !mem_we && mem_addr == src_r)
    else $error("sign character not read first");
  chk_entry_fetch: assert property (
    ctl_go |-> ##[2:14] mem_req && !mem_we && mem_addr == prog_r)
    else $error("first entry not fetched");
  chk_store_ptr: assert property (
    fc_w && hwdata[2:0] == 3'h6 |-> ##[1:8] mem_req && mem_we
    && mem_addr == ea_r)
    else $error("pointer store missing");
  chk_regop_quiet: assert property (
    fc_w && hwdata[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}
    |=> !mem_req [*4])
    else $error("register command touched memory");
endmodule // edit_asserts
bind numeric_edit_and_field_regs edit_asserts u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack));

// *** testbench/mem_model.sv ***
// Purpose: Main memory partner on the edit memory port
// Assumes: Registered ack after a random 0-2 cycle wait
// Notes:   Read data scrambled outside the ack cycle
`timescale 1ns/100ps
module mem_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Request
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  // Answer
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h5A5A;
      wait_r    <= 2'h0;
    end else begin
      // Stale data would hide a late sample
      mem_rdata <= ~mem_rdata;
      mem_ack   <= 1'b0;
      if (mem_ack && mem_req && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      if (mem_req && !mem_ack) begin
        if (wait_r == 2'h0) begin
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
          wait_r    <= 2'($urandom % 3);
        end else begin
          wait_r <= wait_r - 2'h1;
        end
      end
    end
  end
endmodule // mem_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for edit engine and field registers
// Assumes: AHB-Lite master tasks; memory partner with random waits
// Notes:   Drivers queue expectations; a watcher compares results
`timescale 1ns/100ps
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata, mem_addr;
  wire         hreadyout, hresp, mem_req, mem_we, mem_ack;
  wire  [15:0] mem_wdata, mem_rdata;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [63:0] rq[$];
  logic [47:0] wq[$];
  logic [15:0] pg[$], sc[$], ex[$];
  logic        rd_ph = 1'b0;
  logic [31:0] e, r, v;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  numeric_edit_and_field_regs uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_model mm (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  always #4 hclk = ~hclk;
  task automatic check(input [47:0] seen, input [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input bit w, input [7:0] a, input [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input [7:0] a, input [31:0] m, input [31:0] x);
    rq.push_back({m, x});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 300; k++) begin
      rd(8'h10, 32'hFF00_00E0, 32'h0);
      if (v[0] === 1'b0) break;
    end
  endtask
  task automatic run_edit(input bit z, input [31:0] st);
    foreach (pg[i]) mm.mem[8'h10 + i] = pg[i];
    foreach (sc[i]) mm.mem[8'h40 + i] = sc[i];
    foreach (ex[i]) wq.push_back({32'(32'h80 + i), ex[i]});
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h40);
    wr(8'h0C, 32'h80);
    wr(8'h00, {30'h0, z, 1'b1});
    wait_idle;
    rd(8'h10, 32'h00FF_FF1F, st);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watcher takes the oldest note when a result appears
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      check({16'h0, hrdata & rq[0][63:32]}, {16'h0, rq[0][31:0]});
      void'(rq.pop_front());
      rd_ph <= 1'b0;
    end
    if (hsel && htrans[1] && !hwrite && hreadyout) rd_ph <= 1'b1;
    if (mem_req && mem_we && mem_ack)
      check({mem_addr, mem_wdata}, wq.size() ? wq.pop_front() : '0);
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hEF4F8C7D));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Negative source, no skip, float inserted at first nonzero digit
    pg = '{16'h38A4, 16'h5800, 16'h0002, 16'h28AA, 16'h0002, 16'h18AE,
           16'h08C1, 16'h10AA, 16'h6002, 16'h30AB, 16'hF000};
    sc = '{16'h00AD, 16'h00B0, 16'h00B0, 16'h00B1, 16'h00B2};
    ex = '{16'hA0, 16'hA0, 16'hAA, 16'hA4, 16'hB1, 16'hB2, 16'hAE,
           16'hC1, 16'hAA, 16'hAA, 16'hAA, 16'hAD};
    run_edit(1'b0, 32'h00A4_AA1E);
    $display("edit negative done");
    // Zero positive source: skip, sign float, digits
    pg = '{16'h40A4, 16'h5801, 16'h08C1, 16'h28C3, 16'h5000, 16'h2002,
           16'h6800, 16'h18AE, 16'hC8C4};
    sc = '{16'h00AB, 16'h00B0, 16'h00B0};
    ex = '{16'hA0, 16'hAB, 16'hB0, 16'hB0, 16'hAE};
    run_edit(1'b1, 32'h00A0_A016);
    $display("edit zero done");
    // Software keeps lengths within 20 bits
    r = $urandom & 32'h000F_FFFF;
    wr(8'h14, r);
    wr(8'h18, 32'h1);
    wait_idle;
    rd(8'h28, ALL, r);
    e = $urandom & 32'hFC07_FF00;
    wr(8'h1C, e);
    wr(8'h18, 32'hA);
    wait_idle;
    rd(8'h24, ALL, e);
    rd(8'h2C, ALL, 32'h0);
    wr(8'h18, 32'hFFFF_000B);
    wait_idle;
    rd(8'h2C, ALL, 32'h0000_FFFF);
    rd(8'h24, ALL, e);
    wr(8'h14, 32'h18);
    wr(8'h18, 32'hC);
    wait_idle;
    rd(8'h24, ALL, {e[31:26], e[25:0] + 26'h18});
    wr(8'h18, 32'hD);
    wait_idle;
    rd(8'h14, ALL, 32'h0000_FFFF);
    $display("field registers done");
    // Pointer store: three words, then two
    wr(8'h1C, 32'h0400_00D5);
    wr(8'h18, 32'h2);
    wait_idle;
    wr(8'h1C, 32'hD0);
    wq.push_back({32'hD0, 16'h1001});
    wq.push_back({32'hD1, 16'h000D});
    wq.push_back({32'hD2, 16'h5000});
    wr(8'h18, 32'h6);
    wait_idle;
    wr(8'h1C, 32'hE0);
    wr(8'h18, 32'h2);
    wait_idle;
    wq.push_back({32'hE0, 16'h0000});
    wq.push_back({32'hE1, 16'h000E});
    wr(8'h18, 32'h6);
    wait_idle;
    // Read-only and unmapped places ignore writes
    wr(8'h20, $urandom);
    wr(8'h30, $urandom);
    rd(8'h20, ALL, 32'hE0);
    rd(8'h30, ALL, 32'h0);
    repeat (4) @(posedge hclk);
    check(48'(wq.size()), 48'h0);
    $display("pointer store done");
    tally_and_finish;
  end
endmodule // testbench
